// ### usb_fifo_pkg.sv
// constants, field layout and types of the endpoint fifo block
// assumes one 48 MHz clock and an Avalon-MM master for software
package usb_fifo_pkg;
  localparam int NUM_EP    = 8;
  localparam int PW        = 12;
  localparam int MEM_BYTES = 2240;
  localparam int LOG_BYTES = 1120;
  localparam logic [PW-1:0] MEM_TOP = 12'h8C0;
  // byte offsets of the register words
  localparam logic [5:0] OFS_EP_SEL   = 6'h00;
  localparam logic [5:0] OFS_TX_DATA  = 6'h04;
  localparam logic [5:0] OFS_RX_DATA  = 6'h08;
  localparam logic [5:0] OFS_TX_CTRL  = 6'h0C;
  localparam logic [5:0] OFS_RX_CTRL  = 6'h10;
  localparam logic [5:0] OFS_TX_CNT   = 6'h14;
  localparam logic [5:0] OFS_RX_FLAGS = 6'h18;
  localparam logic [5:0] OFS_TX_EN    = 6'h1C;
  localparam logic [5:0] OFS_RX_EN    = 6'h20;
  localparam logic [5:0] OFS_SYS_CTRL = 6'h24;
  localparam logic [5:0] OFS_INT_STAT = 6'h28;
  localparam logic [5:0] OFS_INT_EN   = 6'h2C;
  localparam logic [5:0] OFS_MISC     = 6'h30;
  // fifo control fields
  localparam int F_ISO  = 2;
  localparam int F_MAN  = 3;
  localparam int F_ADV  = 4;
  localparam int F_RWD  = 5;
  localparam int F_DONE = 6;
  localparam int F_SPM  = 7;
  localparam logic [7:0] DONE_MASK = 8'h40;
  // system control fields
  localparam int SYS_GIE = 0;
  localparam int SYS_POL = 1;
  localparam int SYS_LVL = 2;
  // reset values
  localparam logic [7:0] TXCTRL_RST = 8'h00;
  localparam logic [7:0] RXCTRL_RST = 8'h80;
  localparam logic [7:0] EN_RST     = 8'h01;
  localparam logic [2:0] SYS_RST    = 3'h6;
  // device clock derived from the controller clock
  localparam int CTRL_MHZ = 48;
  localparam int DEV_MHZ  = 12;
  localparam logic [1:0] DEV_DIV_LAST = 2'(CTRL_MHZ / DEV_MHZ - 1);

  typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} bus_state_t;

  typedef struct packed {
    logic [2:0] ep;
    logic       rx_wr;
    logic [7:0] rx_data;
    logic       rx_good;
    logic       rx_bad;
    logic       tx_rd;
    logic       tx_good;
    logic       tx_bad;
  } usb_req_t;

  typedef struct packed {
    logic rx_full;
    logic tx_empty;
  } usb_stat_t;

  // logical fifo size from size code, iso bit and extended features
  function automatic logic [PW-1:0] fifo_bytes(input logic [1:0] code, input logic iso, input logic extended_features);
    logic [PW-1:0] r;
    r = 12'h040;
    if (iso) begin
      case (code)
        2'b00:   r = 12'h040;
        2'b01:   r = 12'h100;
        2'b10:   r = 12'h200;
        default: r = 12'h400;
      endcase
    end else begin
      case (code)
        2'b00:   r = 12'h010;
        2'b01:   r = 12'h040;
        2'b10:   r = extended_features ? 12'h008 : 12'h040;
        default: r = extended_features ? 12'h020 : 12'h040;
      endcase
    end
    return r;
  endfunction

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p, input logic [PW-1:0] len);
    return (p + 12'h001 >= len) ? '0 : p + 12'h001;
  endfunction
endpackage

// ### usb_endpoint_fifo_access.sv
// endpoint fifo storage, pointer control, register slave and interrupt logic
// assumes Avalon-MM master on ref_clk_i and a protocol engine on the same clock
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// How it works
// (R1) software keeps enabled logical sizes within 1120
// (R2) dual sets use up to 2240 hidden bytes
// (R3) data ports reach fifo of selected endpoint
// (R4) each data port access steps pointer once
// (R5) read done bit advances set, self clears
// (R6) byte count write moves cpu write set
// (R7) good transaction advances, failure rewinds set start
// (R8) manual bits let firmware own set control
// (R9) transmit fifo always holds two sets
// (R10) receive resets single packet, clear for dual
// (R11) tx: good moves marker, bad rewinds reader
// (R12) rx: good moves marker, bad rewinds writer
// (R13) advance/rewind by hardware or firmware command
// (R14) receive fifo has full and empty flags
// (R15) cpu reads receive set only after ack
// (R16) cpu keeps endpoint select during set read
// (R17) fifo data accesses move exactly one byte
// (R19) each event sets status, enable gates it
// (R20) global mask, polarity and level/pulse select
// (R21) all interrupt sources share equal priority
// (R22) suspend pin raises separate suspend interrupt
// (R23) disabled endpoint gets zero fifo bytes
// (R24) size code picks fifo size per type
// (R25) controller clock divided to device clock
// (R26) combined interrupt from enabled active status bits
module usb_endpoint_fifo_access
  import usb_fifo_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  usb_req_t         usb_req_i,
  output logic      [7:0]  usb_tx_data_o,
  output usb_stat_t        usb_stat_o,
  input  wire logic [7:0]  usb_event_i,
  input  wire logic        suspend_pin_i,
  output logic             combined_irq_o,
  output logic             suspend_irq_o,
  output logic             dev_clk_tick_o
);
  bus_state_t    bus_st_q;
  logic [2:0]    ep_sel_q;
  logic [7:0]    tx_en_q;
  logic [7:0]    rx_en_q;
  logic [7:0]    ist_q;
  logic [7:0]    ien_q;
  logic [2:0]    sys_q;
  logic          extended_features_q;
  logic          irq_prev_q;
  logic          susp1_q;
  logic          susp2_q;
  logic          susp3_q;
  logic          susp_q;
  logic [1:0]    div_q;
  logic [7:0]    mem_q      [MEM_BYTES];
  logic [7:0]    tx_ctrl_q  [NUM_EP];
  logic [7:0]    rx_ctrl_q  [NUM_EP];
  logic [PW-1:0] tx_wp_q    [NUM_EP];
  logic [PW-1:0] tx_rm_q    [NUM_EP];
  logic [PW-1:0] tx_rp_q    [NUM_EP];
  logic [PW-1:0] rx_wm_q    [NUM_EP];
  logic [PW-1:0] rx_wp_q    [NUM_EP];
  logic [PW-1:0] rx_rp_q    [NUM_EP];
  logic [PW-1:0] rx_end0_q  [NUM_EP];
  logic [PW-1:0] rx_end1_q  [NUM_EP];
  logic [1:0]    tx_sets_q  [NUM_EP];
  logic [1:0]    rx_sets_q  [NUM_EP];
  logic [10:0]   tx_cnt_q   [NUM_EP];
  wire  [PW-1:0] tx_len     [NUM_EP];
  wire  [PW-1:0] rx_len     [NUM_EP];
  wire  [PW-1:0] tx_base    [NUM_EP];
  wire  [PW-1:0] rx_base    [NUM_EP];
  wire  [NUM_EP-1:0] tx_full;
  wire  [NUM_EP-1:0] tx_empty;
  wire  [NUM_EP-1:0] rx_full;
  wire  [NUM_EP-1:0] rx_empty;

  // bus decode; an access takes effect in the cycle waitrequest is low
  wire bus_req = read_i | write_i;
  wire acc     = (bus_st_q == BUS_ACK) & bus_req;
  wire acc_wr  = acc & write_i & byteenable_i[0];
  wire byte_be = byteenable_i == 4'h1;
  wire wr_txd  = acc_wr & byte_be & (address_i == OFS_TX_DATA); // R17
  wire rd_rxd  = acc & read_i & byte_be & (address_i == OFS_RX_DATA); // R17

  // selected endpoint views and engine endpoint addresses
  wire [PW-1:0] tx_wp_s   = tx_wp_q[ep_sel_q];
  wire [PW-1:0] tx_len_s  = tx_len[ep_sel_q];
  wire [PW-1:0] rx_rp_s   = rx_rp_q[ep_sel_q];
  wire [PW-1:0] rx_len_s  = rx_len[ep_sel_q];
  wire [1:0]    tx_sets_s = tx_sets_q[ep_sel_q];
  wire [1:0]    rx_sets_s = rx_sets_q[ep_sel_q];
  wire          rx_done_s = rx_ctrl_q[ep_sel_q][F_DONE];
  wire [PW-1:0] tx_wr_adr = tx_base[ep_sel_q] + tx_wp_s; // R3
  wire [PW-1:0] rx_rd_adr = rx_base[ep_sel_q] + rx_rp_s; // R3
  wire [PW-1:0] rx_wr_adr = rx_base[usb_req_i.ep] + rx_wp_q[usb_req_i.ep];
  wire [PW-1:0] tx_rd_adr = tx_base[usb_req_i.ep] + tx_rp_q[usb_req_i.ep];
  wire          tx_rd_ok  = usb_req_i.tx_rd & ~tx_empty[usb_req_i.ep];
  wire          rx_wr_ok  = usb_req_i.rx_wr & ~rx_full[usb_req_i.ep];
  wire [7:0]    rx_byte   = rx_empty[ep_sel_q] ? 8'h00 : mem_q[rx_rd_adr];
  wire [7:0]    flags_s   = {2'b00, tx_sets_s, rx_sets_s, rx_empty[ep_sel_q], rx_full[ep_sel_q]}; // R14

  wire [31:0] rd_word =
    (address_i == OFS_EP_SEL)   ? 32'(ep_sel_q) :
    (address_i == OFS_RX_DATA)  ? 32'(rx_byte) :
    (address_i == OFS_TX_CTRL)  ? 32'(tx_ctrl_q[ep_sel_q]) :
    (address_i == OFS_RX_CTRL)  ? 32'(rx_ctrl_q[ep_sel_q]) :
    (address_i == OFS_TX_CNT)   ? 32'(tx_cnt_q[ep_sel_q]) :
    (address_i == OFS_RX_FLAGS) ? 32'(flags_s) :
    (address_i == OFS_TX_EN)    ? 32'(tx_en_q) :
    (address_i == OFS_RX_EN)    ? 32'(rx_en_q) :
    (address_i == OFS_SYS_CTRL) ? 32'(sys_q) :
    (address_i == OFS_INT_STAT) ? 32'(ist_q) :
    (address_i == OFS_INT_EN)   ? 32'(ien_q) :
    (address_i == OFS_MISC)     ? 32'(extended_features_q) : 32'h0000_0000;

  // one wait state for every access
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      bus_st_q      <= BUS_IDLE;
      waitrequest_o <= 1'b1;
      readdata_o    <= '0;
    end else begin
      bus_st_q      <= (bus_st_q == BUS_IDLE && bus_req) ? BUS_ACK : BUS_IDLE;
      waitrequest_o <= !(bus_st_q == BUS_IDLE && bus_req);
      if (bus_st_q == BUS_IDLE && read_i) begin
        readdata_o <= rd_word;
      end
    end
  end

  // shared storage; writes past the top are dropped
  always_ff @(posedge ref_clk_i) begin
    if (wr_txd && !tx_full[ep_sel_q] && tx_wr_adr < MEM_TOP) begin // R2
      mem_q[tx_wr_adr] <= writedata_i[7:0]; // R2
    end
    if (rx_wr_ok && rx_wr_adr < MEM_TOP) begin
      mem_q[rx_wr_adr] <= usb_req_i.rx_data; // R2
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      usb_tx_data_o <= '0;
      usb_stat_o    <= '0;
    end else begin
      if (tx_rd_ok) begin
        usb_tx_data_o <= mem_q[tx_rd_adr];
      end
      usb_stat_o <= '{rx_full: rx_full[usb_req_i.ep], tx_empty: tx_empty[usb_req_i.ep]}; // R14
    end
  end

  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
    // regions laid out tx0, rx0, tx1, rx1 ...
    wire [PW-1:0] t_log = fifo_bytes(tx_ctrl_q[i][1:0], tx_ctrl_q[i][F_ISO], extended_features_q); // R24
    wire [PW-1:0] r_log = fifo_bytes(rx_ctrl_q[i][1:0], rx_ctrl_q[i][F_ISO], extended_features_q); // R24
    assign tx_len[i] = tx_en_q[i] ? {t_log[PW-2:0], 1'b0} : '0; // R9 R23
    assign rx_len[i] = !rx_en_q[i] ? '0 : rx_ctrl_q[i][F_SPM] ? r_log : {r_log[PW-2:0], 1'b0}; // R10 R23
    if (i == 0) begin : g_first
      assign tx_base[i] = '0;
    end else begin : g_next
      assign tx_base[i] = rx_base[i-1] + rx_len[i-1];
    end
    assign rx_base[i] = tx_base[i] + tx_len[i];

    wire hit   = ep_sel_q == 3'(i);
    wire uhit  = usb_req_i.ep == 3'(i);
    // transmit side
    wire t_iso = tx_ctrl_q[i][F_ISO];
    wire t_man = tx_ctrl_q[i][F_MAN] & ~t_iso;
    wire t_cmd = acc_wr & hit & (address_i == OFS_TX_CTRL);
    wire t_hwg = uhit & (usb_req_i.tx_good | (usb_req_i.tx_bad & t_iso));
    wire t_good = (t_man ? t_cmd & writedata_i[F_ADV] : t_hwg) & (tx_sets_q[i] != 2'd0); // R7 R8 R13
    wire t_bad  = t_man ? t_cmd & writedata_i[F_RWD] : uhit & usb_req_i.tx_bad & ~t_iso; // R7 R8 R13
    wire t_wr   = wr_txd & hit & ~tx_full[i]; // R3
    wire t_rd   = uhit & usb_req_i.tx_rd & ~tx_empty[i];
    wire t_cnt  = acc_wr & hit & (address_i == OFS_TX_CNT) & (tx_sets_q[i] != 2'd2);
    assign tx_full[i]  = (tx_len[i] == '0) | (ptr_inc(tx_wp_q[i], tx_len[i]) == tx_rm_q[i]);
    assign tx_empty[i] = (tx_sets_q[i] == 2'd0) | (tx_rp_q[i] == tx_wp_q[i]);
    // receive side
    wire r_iso = rx_ctrl_q[i][F_ISO];
    wire r_man = rx_ctrl_q[i][F_MAN] & ~r_iso;
    wire r_cmd = acc_wr & hit & (address_i == OFS_RX_CTRL);
    wire r_hwg = uhit & (usb_req_i.rx_good | (usb_req_i.rx_bad & r_iso));
    wire r_good = (r_man ? r_cmd & writedata_i[F_ADV] : r_hwg) & (rx_sets_q[i] != 2'd2); // R7 R8 R13
    wire r_bad  = r_man ? r_cmd & writedata_i[F_RWD] : uhit & usb_req_i.rx_bad & ~r_iso; // R7 R8 R13
    wire r_wr   = uhit & usb_req_i.rx_wr & ~rx_full[i];
    wire r_rd   = rd_rxd & hit & ~rx_empty[i]; // R3
    wire r_done = rx_ctrl_q[i][F_DONE] & (rx_sets_q[i] != 2'd0); // R5
    wire [1:0] r_left = rx_sets_q[i] - {1'b0, r_done};
    assign rx_full[i] = (rx_len[i] == '0) | (rx_sets_q[i] == 2'd2) // R14
                      | (rx_ctrl_q[i][F_SPM] & (rx_sets_q[i] != 2'd0)) // R10
                      | (ptr_inc(rx_wp_q[i], rx_len[i]) == rx_rp_q[i]);
    assign rx_empty[i] = (rx_sets_q[i] == 2'd0) | (rx_rp_q[i] == rx_end0_q[i]); // R14

    always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
        tx_ctrl_q[i] <= TXCTRL_RST;
        tx_wp_q[i]   <= '0;
        tx_rm_q[i]   <= '0;
        tx_rp_q[i]   <= '0;
        tx_sets_q[i] <= '0;
        tx_cnt_q[i]  <= '0;
      end else begin
        if (t_cmd) begin
          tx_ctrl_q[i] <= {4'h0, writedata_i[3:0]};
        end
        if (t_cnt) begin
          tx_cnt_q[i] <= writedata_i[10:0];
        end
        tx_wp_q[i]   <= t_wr ? ptr_inc(tx_wp_q[i], tx_len[i]) : tx_wp_q[i]; // R4
        tx_rm_q[i]   <= t_good ? tx_rp_q[i] : tx_rm_q[i]; // R11
        tx_rp_q[i]   <= t_bad ? tx_rm_q[i] : t_rd ? ptr_inc(tx_rp_q[i], tx_len[i]) : tx_rp_q[i]; // R11
        tx_sets_q[i] <= tx_sets_q[i] + {1'b0, t_cnt} - {1'b0, t_good}; // R6 R9
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
        rx_ctrl_q[i] <= RXCTRL_RST; // R10
        rx_wm_q[i]   <= '0;
        rx_wp_q[i]   <= '0;
        rx_rp_q[i]   <= '0;
        rx_end0_q[i] <= '0;
        rx_end1_q[i] <= '0;
        rx_sets_q[i] <= '0;
      end else begin
        // done bit reads back one cycle then clears
        rx_ctrl_q[i] <= r_cmd ? {writedata_i[F_SPM], writedata_i[F_DONE], 2'b00, writedata_i[3:0]}
                              : rx_ctrl_q[i] & ~DONE_MASK; // R5
        rx_wm_q[i] <= r_good ? rx_wp_q[i] : rx_wm_q[i]; // R12
        rx_wp_q[i] <= r_bad ? rx_wm_q[i] : r_wr ? ptr_inc(rx_wp_q[i], rx_len[i]) : rx_wp_q[i]; // R12
        rx_rp_q[i] <= r_done ? rx_end0_q[i] : r_rd ? ptr_inc(rx_rp_q[i], rx_len[i]) : rx_rp_q[i]; // R4 R5
        if (r_good && r_left == 2'd0) begin
          rx_end0_q[i] <= rx_wp_q[i];
        end else if (r_done) begin
          rx_end0_q[i] <= rx_end1_q[i];
        end
        if (r_good && r_left == 2'd1) begin
          rx_end1_q[i] <= rx_wp_q[i];
        end
        rx_sets_q[i] <= r_left + {1'b0, r_good};
      end
    end
  end

  // global registers, events and interrupt shaping
  wire [7:0] ist_clr = (acc_wr && address_i == OFS_INT_STAT) ? writedata_i[7:0] : 8'h00;
  wire irq_act = sys_q[SYS_GIE] & |(ist_q & ien_q); // R20 R21 R26
  wire irq_on  = sys_q[SYS_LVL] ? irq_act : irq_act & ~irq_prev_q; // R20

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ep_sel_q       <= '0;
      tx_en_q        <= EN_RST;
      rx_en_q        <= EN_RST;
      sys_q          <= SYS_RST;
      ist_q          <= '0;
      ien_q          <= '0;
      extended_features_q         <= 1'b0;
      irq_prev_q     <= 1'b0;
      combined_irq_o <= 1'b0;
    end else begin
      if (acc_wr) begin
        case (address_i)
          OFS_EP_SEL:   ep_sel_q <= writedata_i[2:0];
          OFS_TX_EN:    tx_en_q  <= writedata_i[7:0];
          OFS_RX_EN:    rx_en_q  <= writedata_i[7:0];
          OFS_SYS_CTRL: sys_q    <= writedata_i[2:0];
          OFS_INT_EN:   ien_q    <= writedata_i[7:0];
          OFS_MISC:     extended_features_q   <= writedata_i[0];
          default:      ;
        endcase
      end
      ist_q          <= (ist_q & ~ist_clr) | usb_event_i; // R19
      irq_prev_q     <= irq_act;
      combined_irq_o <= ~(sys_q[SYS_POL] ^ irq_on); // R20 R26
    end
  end

  // suspend pin sync; accepted when stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      susp1_q        <= 1'b0;
      susp2_q        <= 1'b0;
      susp3_q        <= 1'b0;
      susp_q         <= 1'b0;
      suspend_irq_o  <= 1'b0;
      div_q          <= '0;
      dev_clk_tick_o <= 1'b0;
    end else begin
      susp1_q        <= suspend_pin_i;
      susp2_q        <= susp1_q;
      susp3_q        <= susp2_q;
      susp_q         <= (susp2_q == susp3_q) ? susp2_q : susp_q;
      suspend_irq_o  <= susp_q; // R22
      div_q          <= (div_q == DEV_DIV_LAST) ? 2'b00 : div_q + 2'b01; // R25
      dev_clk_tick_o <= div_q == DEV_DIV_LAST; // R25
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_req_idle;
    bus_req && bus_st_q == BUS_IDLE;
  endsequence
  sequence s_one_wait;
    !waitrequest_o ##1 waitrequest_o;
  endsequence
  a_bus_one_wait: assert property (s_req_idle |=> s_one_wait)
    else $error("bus answer not after one wait state");
  a_tx_wptr_step: assert property (wr_txd && !tx_full[ep_sel_q] |=> tx_wp_s == ptr_inc($past(tx_wp_s), $past(tx_len_s))) // R4
    else $error("tx write pointer did not step by one");
  a_rx_rptr_step: assert property (rd_rxd && !rx_empty[ep_sel_q] && !rx_done_s |=> rx_rp_s == ptr_inc($past(rx_rp_s), $past(rx_len_s))) // R4
    else $error("rx read pointer did not step by one");
  a_done_self_clear: assert property ($rose(rx_done_s) |=> !rx_done_s) // R5
    else $error("rx read done bit did not clear");
  a_cnt_moves_set: assert property (acc_wr && address_i == OFS_TX_CNT && tx_sets_s == 2'd0 |=> tx_sets_s == 2'd1) // R6
    else $error("byte count write did not add a set");
  a_rx_bad_rewind: assert property (usb_req_i.ep == 3'd0 && usb_req_i.rx_bad && rx_ctrl_q[0][3:2] == 2'b00 // R12
                                    |=> rx_wp_q[0] == $past(rx_wm_q[0]))
    else $error("rx write pointer not rewound");
  a_tx_good_marker: assert property (usb_req_i.ep == 3'd0 && usb_req_i.tx_good && tx_ctrl_q[0][3:2] == 2'b00 // R11
                                     && tx_sets_q[0] != 2'd0 |=> tx_rm_q[0] == $past(tx_rp_q[0]))
    else $error("tx read marker not advanced");
  a_manual_hold: assert property (usb_req_i.ep == 3'd0 && usb_req_i.tx_bad && !usb_req_i.tx_rd && !acc // R8
                                  && tx_ctrl_q[0][3:2] == 2'b10 |=> $stable(tx_rp_q[0]))
    else $error("hardware rewind in manual mode");
  a_spm_after_reset: assert property ($rose(rstn_i) |-> rx_ctrl_q[0][F_SPM]) // R10
    else $error("rx single packet not set after reset");
  a_irq_level: assert property (sys_q[SYS_LVL] |=> combined_irq_o == ($past(sys_q[SYS_POL]) ~^ $past(irq_act))) // R26
    else $error("level interrupt wrong");
  a_irq_pulse: assert property (!sys_q[SYS_LVL] && sys_q[SYS_POL] && combined_irq_o |=> !combined_irq_o || sys_q[SYS_LVL]) // R20
    else $error("pulse interrupt longer than one cycle");
  a_event_sticky: assert property (|usb_event_i |=> (ist_q & $past(usb_event_i)) == $past(usb_event_i)) // R19
    else $error("event lost");
  a_suspend_irq: assert property (susp2_q && susp3_q |=> ##1 suspend_irq_o) // R22
    else $error("suspend interrupt missing");
  a_disabled_zero: assert property (!rx_en_q[usb_req_i.ep] |-> rx_len[usb_req_i.ep] == '0) // R23
    else $error("disabled endpoint has storage");

  // set and pointer movement
  a_rx_good_adv: assert property (usb_req_i.ep == 3'd0 && usb_req_i.rx_good && rx_sets_q[0] == 2'd0 // R7 R12
                                  && rx_ctrl_q[0][3:2] == 2'b00
                                  |=> rx_wm_q[0] == $past(rx_wp_q[0]) && rx_sets_q[0] == 2'd1)
    else $error("rx write marker not advanced");
  a_tx_bad_rewind: assert property (usb_req_i.ep == 3'd3 && usb_req_i.tx_bad && tx_ctrl_q[3][3:2] == 2'b00 // R7 R11
                                    |=> tx_rp_q[3] == $past(tx_rm_q[3]))
    else $error("tx read pointer not rewound");
  a_fw_rewind: assert property (acc_wr && address_i == OFS_TX_CTRL && writedata_i[F_RWD] // R8 R13
                                && ep_sel_q == 3'd0 && tx_ctrl_q[0][3:2] == 2'b10
                                |=> tx_rp_q[0] == $past(tx_rm_q[0]))
    else $error("firmware rewind not taken");
  a_rx_empty_hold: assert property (rd_rxd && rx_empty[ep_sel_q] && !rx_done_s |=> $stable(rx_rp_s)) // R14
    else $error("rx read pointer moved on empty fifo");

  sequence s_tick_gap;
    (!dev_clk_tick_o) [*3];
  endsequence
  a_tick_period: assert property (dev_clk_tick_o |=> s_tick_gap ##1 dev_clk_tick_o) // R25
    else $error("device clock tick period wrong");
endmodule // usb_endpoint_fifo_access

// ### usb_engine_model.sv
// protocol engine model on the usb side of the endpoint fifo block
// assumes the fifo block samples usb_req_o on rising edges of ref_clk_i
`timescale 1ns/1ns
module usb_engine_model
  import usb_fifo_pkg::*;
(
  input  wire logic ref_clk_i,
  output usb_req_t  usb_req_o
);
  logic [7:0] last_q;

  initial begin
    usb_req_o = '0;
    last_q    = 8'h00;
  end

  // kind: 0 rx byte, 1 rx good, 2 rx bad, 3 tx read, 4 tx good, 5 tx bad
  // good or bad only after the last byte of a set; idle data never repeats the last byte
  task automatic send(input logic [2:0] ep, input int kind, input logic [7:0] data);
    usb_req_t r;
    r         = '0;
    r.ep      = ep;
    r.rx_data = (kind == 0) ? data : ~last_q;
    r.rx_wr   = (kind == 0);
    r.rx_good = (kind == 1);
    r.rx_bad  = (kind == 2);
    r.tx_rd   = (kind == 3);
    r.tx_good = (kind == 4);
    r.tx_bad  = (kind == 5);
    @(posedge ref_clk_i);
    usb_req_o <= r;
    if (kind == 0) begin
      last_q = data;
    end
    r         = '0;
    r.ep      = ep;
    r.rx_data = ~last_q;
    @(posedge ref_clk_i);
    usb_req_o <= r;
  endtask
endmodule // usb_engine_model

// ### tb.sv
// self-checking bench for the endpoint fifo block
// assumes the package and the protocol engine model are compiled first
`timescale 1ns/1ns
module tb
  import usb_fifo_pkg::*;
;
  logic        ref_clk_i;
  logic        rstn_i;
  logic [5:0]  address_i;
  logic        read_i;
  logic        write_i;
  logic [31:0] writedata_i;
  logic [3:0]  byteenable_i;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  usb_req_t    usb_req_i;
  logic [7:0]  usb_tx_data_o;
  usb_stat_t   usb_stat_o;
  logic [7:0]  usb_event_i;
  logic        suspend_pin_i;
  logic        combined_irq_o;
  logic        suspend_irq_o;
  logic        dev_clk_tick_o;
  int          error_cnt;
  int          tests_run;
  int          seed;
  int          n;
  int          p;
  logic [31:0] rd;
  logic [7:0]  pay [4];

  usb_endpoint_fifo_access i_usb_endpoint_fifo_access (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .usb_req_i(usb_req_i), .usb_tx_data_o(usb_tx_data_o),
    .usb_stat_o(usb_stat_o), .usb_event_i(usb_event_i), .suspend_pin_i(suspend_pin_i),
    .combined_irq_o(combined_irq_o), .suspend_irq_o(suspend_irq_o), .dev_clk_tick_o(dev_clk_tick_o));
  usb_engine_model i_usb_engine_model (.ref_clk_i(ref_clk_i), .usb_req_o(usb_req_i));

  always #20 ref_clk_i = ~ref_clk_i;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    read_i      <= ~wr;
    write_i     <= wr;
    address_i   <= adr;
    writedata_i <= wd;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (waitrequest_o !== 1'b0 && k < 50);
    rd = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
    end
  endtask

  task automatic rd_chk(input logic [5:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check({31'h0, combined_irq_o}, {31'h0, exp});
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    give_verdict();
  end

  initial begin
    ref_clk_i = 1'b0; rstn_i = 1'b0; address_i = '0; read_i = 1'b0; write_i = 1'b0;
    writedata_i = '0; byteenable_i = 4'h1; usb_event_i = '0; suspend_pin_i = 1'b0;
    error_cnt = 0; tests_run = 0; seed = 32'hd687_b0a4; n = 0;
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_chk(OFS_RX_CTRL, {24'h0, RXCTRL_RST});
    rd_chk(OFS_SYS_CTRL, {29'h0, SYS_RST});
    rd_chk(OFS_RX_EN, {24'h0, EN_RST});
    rd_chk(OFS_RX_FLAGS, 32'h0000_0002);
    rd_chk(6'h34, 32'h0000_0000);
    // disabled receive endpoint reports full to the engine
    i_usb_engine_model.send(3'd5, 0, 8'hA5);
    @(negedge ref_clk_i);
    check({31'h0, usb_stat_o.rx_full}, 32'h0000_0001);
    // bad packet rewinds the writer, then the same bytes land as a good set
    for (p = 0; p < 2; p++) begin
      for (n = 0; n < 4; n++) begin
        if (p == 0) pay[n] = 8'($random(seed));
        i_usb_engine_model.send(3'd0, 0, pay[n]);
      end
      i_usb_engine_model.send(3'd0, (p == 0) ? 2 : 1, 8'h00);
      rd_chk(OFS_RX_FLAGS, (p == 0) ? 32'h0000_0002 : 32'h0000_0005);
    end
    for (n = 0; n < 4; n++) rd_chk(OFS_RX_DATA, {24'h0, pay[n]});
    rd_chk(OFS_RX_DATA, 32'h0000_0000);
    bus(1'b1, OFS_RX_CTRL, 32'h0000_00C0);
    rd_chk(OFS_RX_CTRL, 32'h0000_0080);
    rd_chk(OFS_RX_FLAGS, 32'h0000_0002);
    // transmit set on endpoint 3, retried once after a bad transmission
    bus(1'b1, OFS_TX_EN, 32'h0000_0009);
    bus(1'b1, OFS_EP_SEL, 32'h0000_0003);
    for (n = 0; n < 3; n++) begin
      pay[n] = 8'($random(seed));
      bus(1'b1, OFS_TX_DATA, {24'h0, pay[n]});
    end
    bus(1'b1, OFS_TX_CNT, 32'h0000_0003);
    bus(1'b0, OFS_RX_FLAGS, 32'h0000_0000);
    check(rd & 32'h0000_0030, 32'h0000_0010);
    for (p = 0; p < 2; p++) begin
      for (n = 0; n < 3; n++) begin
        i_usb_engine_model.send(3'd3, 3, 8'h00);
        @(negedge ref_clk_i);
        check({24'h0, usb_tx_data_o}, {24'h0, pay[n]});
      end
      i_usb_engine_model.send(3'd3, (p == 0) ? 5 : 4, 8'h00);
    end
    bus(1'b0, OFS_RX_FLAGS, 32'h0000_0000);
    check(rd & 32'h0000_0030, 32'h0000_0000);
    // manual set control on endpoint 0: engine rewind ignored, firmware commands taken
    bus(1'b1, OFS_EP_SEL, 32'h0000_0000);
    bus(1'b1, OFS_TX_CTRL, 32'h0000_0008);
    bus(1'b1, OFS_TX_DATA, {24'h0, pay[2]});
    bus(1'b1, OFS_TX_CNT, 32'h0000_0001);
    for (p = 0; p < 2; p++) begin
      i_usb_engine_model.send(3'd0, 3, 8'h00);
      @(negedge ref_clk_i);
      check({31'h0, usb_stat_o.tx_empty}, 32'h0000_0000);
      check({24'h0, usb_tx_data_o}, {24'h0, pay[2]});
      i_usb_engine_model.send(3'd0, 5, 8'h00);
      @(negedge ref_clk_i);
      check({31'h0, usb_stat_o.tx_empty}, 32'h0000_0001);
      bus(1'b1, OFS_TX_CTRL, (p == 0) ? 32'h0000_0028 : 32'h0000_0018);
    end
    bus(1'b0, OFS_RX_FLAGS, 32'h0000_0000);
    check(rd & 32'h0000_0030, 32'h0000_0000);
    // interrupt status, enable, global mask and level/pulse select
    bus(1'b1, OFS_INT_EN, 32'h0000_0004);
    @(posedge ref_clk_i);
    usb_event_i <= 8'h44;
    @(posedge ref_clk_i);
    usb_event_i <= 8'h00;
    rd_chk(OFS_INT_STAT, 32'h0000_0044);
    irq_chk(1'b0);
    bus(1'b1, OFS_SYS_CTRL, 32'h0000_0007);
    irq_chk(1'b1);
    bus(1'b1, OFS_SYS_CTRL, 32'h0000_0003);
    irq_chk(1'b0);
    bus(1'b1, OFS_INT_STAT, 32'h0000_0004);
    irq_chk(1'b0);
    rd_chk(OFS_INT_STAT, 32'h0000_0040);
    // pulse mode: one active cycle per new event
    usb_event_i <= 8'h04;
    @(posedge ref_clk_i);
    usb_event_i <= 8'h00;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check({31'h0, combined_irq_o}, 32'h0000_0001);
    @(negedge ref_clk_i);
    check({31'h0, combined_irq_o}, 32'h0000_0000);
    // suspend pin to its own interrupt
    @(posedge ref_clk_i);
    suspend_pin_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check({31'h0, suspend_irq_o}, 32'h0000_0001);
    @(posedge ref_clk_i);
    suspend_pin_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check({31'h0, suspend_irq_o}, 32'h0000_0000);
    // device clock tick rate
    n = 0;
    repeat (40) begin
      @(negedge ref_clk_i);
      if (dev_clk_tick_o === 1'b1) n++;
    end
    check(32'(n), 32'(40 * DEV_MHZ / CTRL_MHZ));
    give_verdict();
  end
endmodule // tb
